// ===== pfcls_top.sv
// pfcls_top.sv - pwm timebase, conversion triggers and loop scheduling for a two-leg pfc
// assumes the converter delivers samples on this clock, in trigger order, with adc_valid_i
`timescale 1ns/1ps
`include "pfcls_map.svh"

module pfcls_top
  import pfcls_pkg::*;
#(
  parameter int PERIOD_CYC = `PFCLS_PWM_PERIOD_CYC,
  parameter int MID_CMP    = `PFCLS_MID_CMP_CYC,
  parameter int SLOW_CYC   = `PFCLS_SLOW_CYC,
  parameter int CONV_CYC   = `PFCLS_CONV_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        run_i,
  input  wire pfcls_frac_t vbus_ref_i,
  input  wire logic        adc_valid_i,
  input  wire pfcls_frac_t adc_data_i,
  output logic             mid_trig_o,
  output logic             end_trig_o,
  output logic             adc_start_o,
  output logic             fast_tick_o,
  output logic             slow_tick_o,
  output logic             conv_late_o,
  output logic             duty_upd_o,
  output pfcls_frac_t      duty1_o,
  output pfcls_frac_t      duty2_o,
  output pfcls_frac_t      iref_o,
  output pfcls_samples_s   samples_o
);

  // ------------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------------
  if (PERIOD_CYC < 16 || PERIOD_CYC > 65536 || MID_CMP < 1 || MID_CMP >= PERIOD_CYC - 1 ||
      SLOW_CYC < PERIOD_CYC || SLOW_CYC > 262144 || (SLOW_CYC % PERIOD_CYC) != 0 ||
      CONV_CYC < 1 ||
      CONV_CYC > PERIOD_CYC) begin : g_chk
    $error("pfcls_top parameters out of range");
  end

  // ------------------------------------------------------------------
  // pwm timebase
  // ------------------------------------------------------------------
  logic [15:0] cnt_q;
  logic        parity_q;
  logic [17:0] slow_cnt_q;
  logic        mid_hit;
  logic        end_hit;
  logic        fast_hit;
  logic        slow_hit;

  // compare decode against the period counter and the slow divider
  assign mid_hit  = (cnt_q == 16'(MID_CMP));
  assign end_hit  = (cnt_q == 16'(PERIOD_CYC - 1));
  assign fast_hit = end_hit && parity_q;
  assign slow_hit = (slow_cnt_q == 18'(SLOW_CYC - 1));

  // period counter and period parity
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      cnt_q    <= 16'h0000;
      parity_q <= 1'b0;
    end else if (end_hit) begin
      cnt_q    <= 16'h0000;
      parity_q <= !parity_q;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // slow task divider, aligned to period ends from reset
  always_ff @(posedge clock_i) begin
    if (!rstn_i || slow_hit) begin
      slow_cnt_q <= 18'h00000;
    end else begin
      slow_cnt_q <= slow_cnt_q + 18'h00001;
    end
  end

  // trigger and tick outputs
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      mid_trig_o  <= 1'b0;
      end_trig_o  <= 1'b0;
      adc_start_o <= 1'b0;
      fast_tick_o <= 1'b0;
      slow_tick_o <= 1'b0;
    end else begin
      mid_trig_o  <= mid_hit;
      end_trig_o  <= end_hit;
      adc_start_o <= mid_hit || end_hit;
      fast_tick_o <= fast_hit;
      slow_tick_o <= slow_hit;
    end
  end

  // ------------------------------------------------------------------
  // sample capture
  // ------------------------------------------------------------------
  logic [2:0]     idx_q;
  logic           mid_done_q;
  logic           end_done_q;
  pfcls_samples_s smp_q;

  // sequence index steps through the samples of the current trigger
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      idx_q <= `PFCLS_IDX_NONE;
    end else if (mid_hit) begin
      idx_q <= `PFCLS_IDX_VIN;
    end else if (end_hit) begin
      idx_q <= `PFCLS_IDX_I2;
    end else if (adc_valid_i && idx_q != `PFCLS_IDX_NONE) begin
      if (idx_q == `PFCLS_IDX_I1 || idx_q == `PFCLS_IDX_TEMP) begin
        idx_q <= `PFCLS_IDX_NONE;
      end else begin
        idx_q <= idx_q + 3'h1;
      end
    end
  end

  // store each sample by its place in the sequence
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      smp_q <= '0;
    end else if (adc_valid_i) begin
      case (idx_q)
        `PFCLS_IDX_VIN:  smp_q.vin  <= adc_data_i;
        `PFCLS_IDX_VBUS: smp_q.vbus <= adc_data_i;
        `PFCLS_IDX_I1:   smp_q.i1   <= adc_data_i;
        `PFCLS_IDX_I2:   smp_q.i2   <= adc_data_i;
        `PFCLS_IDX_TEMP: smp_q.temp <= adc_data_i;
        default:         smp_q      <= smp_q;
      endcase
    end
  end

  // completion flags, cleared by the trigger that starts a new sequence
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      mid_done_q <= 1'b0;
      end_done_q <= 1'b0;
    end else begin
      if (mid_hit) begin
        mid_done_q <= 1'b0;
      end else if (adc_valid_i && idx_q == `PFCLS_IDX_I1) begin
        mid_done_q <= 1'b1;
      end
      if (end_hit) begin
        end_done_q <= 1'b0;
      end else if (adc_valid_i && idx_q == `PFCLS_IDX_TEMP) begin
        end_done_q <= 1'b1;
      end
    end
  end

  assign samples_o = smp_q;

  // ------------------------------------------------------------------
  // task scheduler
  // ------------------------------------------------------------------
  pfcls_state_e       state_q;
  logic [15:0]        wait_cnt_q;
  logic               slow_pend_q;
  logic               seq_done;
  logic               go_fast;
  logic               go_slow;
  logic [1:0]         pi_chan;
  pfcls_frac_t        pi_ref;
  pfcls_frac_t        pi_meas;
  logic signed [31:0] pi_kp;
  logic signed [31:0] pi_ki;
  logic               pi_done;
  logic [1:0]         pi_done_chan;
  pfcls_frac_t        pi_out;
  logic signed [16:0] vin_abs;

  assign seq_done = mid_done_q && end_done_q;

  // fast work owns the evaluator; slow work only fills idle cycles
  assign go_fast = (state_q == PFCLS_LEG1) || (state_q == PFCLS_LEG2);
  assign go_slow = slow_pend_q && !go_fast && run_i;

  // operand selection for the shared evaluator
  always_comb begin
    pi_chan = `PFCLS_CH_VBUS;
    pi_ref  = vbus_ref_i;
    pi_meas = smp_q.vbus;
    pi_kp   = `PFCLS_U_KP;
    pi_ki   = `PFCLS_U_KI;
    case (state_q)
      PFCLS_LEG1: begin
        pi_chan = `PFCLS_CH_LEG1;
        pi_ref  = iref_o;
        pi_meas = smp_q.i1;
        pi_kp   = `PFCLS_I_KP;
        pi_ki   = `PFCLS_I_KI;
      end
      PFCLS_LEG2: begin
        pi_chan = `PFCLS_CH_LEG2;
        pi_ref  = iref_o;
        pi_meas = smp_q.i2;
        pi_kp   = `PFCLS_I_KP;
        pi_ki   = `PFCLS_I_KI;
      end
      default: begin
        pi_chan = `PFCLS_CH_VBUS;
      end
    endcase
  end

  // current task sequencing with the conversion budget
  always_ff @(posedge clock_i) begin
    if (!rstn_i || !run_i) begin
      state_q     <= PFCLS_IDLE;
      wait_cnt_q  <= 16'h0000;
      conv_late_o <= 1'b0;
    end else begin
      conv_late_o <= 1'b0;
      case (state_q)
        PFCLS_IDLE: begin
          wait_cnt_q <= 16'h0000;
          if (fast_hit) begin
            state_q <= PFCLS_WAIT;
          end
        end
        PFCLS_WAIT: begin
          wait_cnt_q <= wait_cnt_q + 16'h0001;
          if (seq_done) begin
            state_q <= PFCLS_LEG1;
          end else if (wait_cnt_q == 16'(CONV_CYC)) begin
            state_q     <= PFCLS_IDLE;
            conv_late_o <= 1'b1;
          end
        end
        PFCLS_LEG1: state_q <= PFCLS_LEG2;
        PFCLS_LEG2: state_q <= PFCLS_IDLE;
        default:    state_q <= PFCLS_IDLE;
      endcase
    end
  end

  // slow request waits until the evaluator is free; a new tick wins over the clear
  always_ff @(posedge clock_i) begin
    if (!rstn_i || !run_i) begin
      slow_pend_q <= 1'b0;
    end else if (slow_hit) begin
      slow_pend_q <= 1'b1;
    end else if (go_slow) begin
      slow_pend_q <= 1'b0;
    end
  end

  pfcls_pi #(
    .CHANNELS (3)
  ) u_pi (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .clear_i (!run_i),
    .start_i (go_fast || go_slow),
    .chan_i  (pi_chan),
    .ref_i   (pi_ref),
    .meas_i  (pi_meas),
    .kp_i    (pi_kp),
    .ki_i    (pi_ki),
    .done_o  (pi_done),
    .chan_o  (pi_done_chan),
    .out_o   (pi_out)
  );

  // rectified input voltage shapes the current reference
  assign vin_abs = smp_q.vin[15] ? -17'(smp_q.vin) : 17'(smp_q.vin);

  // controller results to duties and reference; duties never go negative
  always_ff @(posedge clock_i) begin
    if (!rstn_i || !run_i) begin
      duty1_o    <= `PFCLS_FRAC_RST;
      duty2_o    <= `PFCLS_FRAC_RST;
      iref_o     <= `PFCLS_FRAC_RST;
      duty_upd_o <= 1'b0;
    end else begin
      duty_upd_o <= pi_done && pi_done_chan == `PFCLS_CH_LEG2;
      if (pi_done) begin
        case (pi_done_chan)
          `PFCLS_CH_LEG1: duty1_o <= pi_out[15] ? `PFCLS_FRAC_RST : pi_out;
          `PFCLS_CH_LEG2: duty2_o <= pi_out[15] ? `PFCLS_FRAC_RST : pi_out;
          `PFCLS_CH_VBUS: iref_o  <= pfcls_sat16(pfcls_mul_q(vin_abs, 32'(pi_out)));
          default:        iref_o  <= iref_o;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  logic [15:0] per_since_q;

  // periods counted since the last current task tick
  always_ff @(posedge clock_i) begin
    if (!rstn_i || fast_tick_o) begin
      per_since_q <= 16'h0000;
    end else if (end_trig_o) begin
      per_since_q <= per_since_q + 16'h0001;
    end
  end

  a_start_is_or: assert property (@(posedge clock_i) disable iff (!rstn_i)
    adc_start_o == (mid_trig_o || end_trig_o))
    else $error("conversion start differs from trigger or");

  a_two_trig_sep: assert property (@(posedge clock_i) disable iff (!rstn_i)
    end_trig_o |-> (!mid_trig_o && cnt_q == 16'h0000))
    else $error("end trigger not at period wrap or overlaps mid trigger");

  a_mid_place: assert property (@(posedge clock_i) disable iff (!rstn_i)
    mid_trig_o |-> cnt_q == 16'(MID_CMP + 1))
    else $error("mid trigger not at mid-period compare");

  a_fast_rate: assert property (@(posedge clock_i) disable iff (!rstn_i)
    fast_tick_o |-> (end_trig_o && per_since_q == 16'h0001))
    else $error("current task not every second period");

  a_slow_rate: assert property (@(posedge clock_i) disable iff (!rstn_i)
    slow_tick_o |-> (end_trig_o && slow_cnt_q == 18'h00000))
    else $error("voltage task not aligned to period end");

  a_slow_yields: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (slow_tick_o && run_i && $past(run_i)) |-> (go_slow != go_fast))
    else $error("voltage task neither started nor deferred to current task");

  a_wait_conv: assert property (@(posedge clock_i) disable iff (!rstn_i)
    go_fast |-> seq_done)
    else $error("leg controller evaluated before conversions ended");

  a_conv_budget: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (state_q == PFCLS_WAIT) |-> wait_cnt_q <= 16'(CONV_CYC))
    else $error("conversion wait exceeded its budget");

  a_duty_before: assert property (@(posedge clock_i) disable iff (!rstn_i || !run_i)
    (state_q == PFCLS_IDLE && fast_hit) |-> ##[1:170] (duty_upd_o || conv_late_o))
    else $error("leg duties not refreshed within the current task");

endmodule

// ===== pfcls_map.svh
// pfcls_map.svh - timing counts, gains, indices and reset values of the loop scheduler
// assumes a 200 MHz system clock; included by bare name
`ifndef PFCLS_MAP_SVH
`define PFCLS_MAP_SVH

// ------------------------------------------------------------------
// clock and timebase
// ------------------------------------------------------------------
`define PFCLS_CLK_NS          5
`define PFCLS_PWM_PERIOD_NS   10000
`define PFCLS_PWM_PERIOD_CYC  (`PFCLS_PWM_PERIOD_NS / `PFCLS_CLK_NS)
`define PFCLS_MID_CMP_CYC     (`PFCLS_PWM_PERIOD_CYC / 2)
`define PFCLS_SLOW_NS         1000000
`define PFCLS_SLOW_CYC        (`PFCLS_SLOW_NS / `PFCLS_CLK_NS)
`define PFCLS_CONV_NS         780
`define PFCLS_CONV_CYC        (`PFCLS_CONV_NS / `PFCLS_CLK_NS)

// ------------------------------------------------------------------
// fixed-point pi gains, 15 fractional bits
// ------------------------------------------------------------------
`define PFCLS_FRAC_BITS       15
`define PFCLS_I_KP            32'sh0000_29ba
`define PFCLS_I_KI            32'sh0000_0158
`define PFCLS_U_KP            32'sh0002_d2f2
`define PFCLS_U_KI            32'sh0000_057a

// ------------------------------------------------------------------
// pi channels and sample sequence indices
// ------------------------------------------------------------------
`define PFCLS_CH_LEG1         2'h0
`define PFCLS_CH_LEG2         2'h1
`define PFCLS_CH_VBUS         2'h2
`define PFCLS_IDX_VIN         3'h0
`define PFCLS_IDX_VBUS        3'h1
`define PFCLS_IDX_I1          3'h2
`define PFCLS_IDX_I2          3'h3
`define PFCLS_IDX_TEMP        3'h4
`define PFCLS_IDX_NONE        3'h7
`define PFCLS_FRAC_RST        16'sh0000

`endif

// ===== pfcls_pkg.sv
// pfcls_pkg.sv - types and fixed-point helpers shared by the loop scheduler files
// assumes pfcls_map.svh is on the include path
`include "pfcls_map.svh"

package pfcls_pkg;

  typedef logic signed [15:0] pfcls_frac_t;

  // scheduler states, one-hot
  typedef enum logic [3:0] {
    PFCLS_IDLE = 4'h1,
    PFCLS_WAIT = 4'h2,
    PFCLS_LEG1 = 4'h4,
    PFCLS_LEG2 = 4'h8
  } pfcls_state_e;

  // one full set of converter samples
  typedef struct packed {
    pfcls_frac_t vin;
    pfcls_frac_t vbus;
    pfcls_frac_t i1;
    pfcls_frac_t i2;
    pfcls_frac_t temp;
  } pfcls_samples_s;

  // signed product rescaled by the fraction bits
  function automatic logic signed [49:0] pfcls_mul_q(input logic signed [16:0] a,
                                                     input logic signed [31:0] b);
    logic signed [48:0] p;
    p = a * b;
    return 50'(p >>> `PFCLS_FRAC_BITS);
  endfunction

  function automatic logic signed [31:0] pfcls_sat32(input logic signed [49:0] v);
    if (v > 50'sh0_0000_7fff_ffff) return 32'sh7fff_ffff;
    else if (v < -50'sh0_0000_8000_0000) return -32'sh7fff_ffff - 32'sh1;
    else return v[31:0];
  endfunction

  function automatic pfcls_frac_t pfcls_sat16(input logic signed [49:0] v);
    if (v > 50'sh0_0000_0000_7fff) return 16'sh7fff;
    else if (v < -50'sh0_0000_0000_8000) return -16'sh7fff - 16'sh1;
    else return v[15:0];
  endfunction

endpackage

// ===== pfcls_pi.sv
// pfcls_pi.sv - shared parallel pi evaluator with one integrator per channel
// assumes start pulses on the system clock; result follows one cycle later
`timescale 1ns/1ps

module pfcls_pi
  import pfcls_pkg::*;
#(
  parameter int CHANNELS = 3
) (
  input  wire logic               clock_i,
  input  wire logic               rstn_i,
  input  wire logic               clear_i,
  input  wire logic               start_i,
  input  wire logic [1:0]         chan_i,
  input  wire pfcls_frac_t        ref_i,
  input  wire pfcls_frac_t        meas_i,
  input  wire logic signed [31:0] kp_i,
  input  wire logic signed [31:0] ki_i,
  output logic                    done_o,
  output logic [1:0]              chan_o,
  output pfcls_frac_t             out_o
);

  // ------------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------------
  if (CHANNELS < 3 || CHANNELS > 4) begin : g_chk
    $error("pfcls_pi needs three or four channels");
  end

  logic signed [31:0] integ_q [CHANNELS];
  logic signed [16:0] err;
  logic signed [31:0] p_term;
  logic signed [31:0] integ_d;

  // error, proportional term and saturated integrator update
  always_comb begin
    err     = 17'(ref_i) - 17'(meas_i);
    p_term  = pfcls_sat32(pfcls_mul_q(err, kp_i));
    integ_d = pfcls_sat32(50'(integ_q[chan_i]) + pfcls_mul_q(err, ki_i));
  end

  // per-channel integrator memory
  always_ff @(posedge clock_i) begin
    if (!rstn_i || clear_i) begin
      for (int k = 0; k < CHANNELS; k++) begin
        integ_q[k] <= 32'sh0;
      end
    end else if (start_i) begin
      integ_q[chan_i] <= integ_d;
    end
  end

  // registered result
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      done_o <= 1'b0;
      chan_o <= 2'h0;
      out_o  <= `PFCLS_FRAC_RST;
    end else begin
      done_o <= start_i && !clear_i;
      if (start_i) begin
        chan_o <= chan_i;
        out_o  <= pfcls_sat16(50'(p_term) + 50'(integ_d));
      end
    end
  end

  a_pi_result: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (start_i && !clear_i) |=> (done_o && chan_o == $past(chan_i)))
    else $error("pi result not presented one cycle after start");

endmodule

// ===== pfcls_conv_model.sv
// converter model: answers each conversion start with a burst of samples, except end starts while drop_i is high
// assumes start, mid flag and sample values on the system clock
`timescale 1ns/1ps

module pfcls_conv_model
  import pfcls_pkg::*;
(
  input  wire logic           clock_i,
  input  wire logic           start_i,
  input  wire logic           mid_i,
  input  wire logic           drop_i,
  input  wire logic [7:0]     lag_i,
  input  wire pfcls_samples_s samp_i,
  output logic                valid_o,
  output pfcls_frac_t         data_o
);
  pfcls_frac_t seq[$];

  // -----------------------------------------------------------------
  // sequence player
  // -----------------------------------------------------------------
  // one process owns the outputs; drop_i loses the end burst for the late path
  initial begin
    valid_o = 1'b0;
    data_o  = 16'sh0000;
    forever begin
      @(posedge clock_i);
      if (start_i === 1'b1 && (mid_i === 1'b1 || !drop_i)) begin
        if (mid_i) seq = '{samp_i.vin, samp_i.vbus, samp_i.i1};
        else seq = '{samp_i.i2, samp_i.temp};
        repeat (lag_i) @(posedge clock_i);
        while (seq.size() > 0) begin
          #1;
          valid_o = 1'b1;
          data_o  = seq.pop_front();
          @(posedge clock_i);
        end
        #1;
        valid_o = 1'b0;
        data_o  = ~data_o; // released line shows no stale sample
      end
    end
  end
endmodule

// ===== tb_top.sv
// testbench: timebase, trigger, scheduling and pi checks against a reference model
// assumes pfcls_top with a shortened pwm period and the converter model
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error at %0t ns: got %0h expected %0h", $time, g, e); end end

module tb_top;
  import pfcls_pkg::*;
  localparam int PER = 200;
  localparam int MID = 100;
  localparam int SLW = 1000;
  localparam int CNV = 156;
  logic           clock_i = 1'b0;
  logic           rstn_i  = 1'b0;
  logic           run_i   = 1'b0;
  logic           drop    = 1'b0;
  logic [7:0]     lag     = 8'h04;
  pfcls_frac_t    vref    = 16'sh0000;
  pfcls_samples_s samp    = '0;
  logic           valid, mid_t, end_t, start, fast, slow, late, upd;
  pfcls_frac_t    data, duty1, duty2, iref;
  pfcls_samples_s samples;
  int             fail_count = 0, n_checks = 0, cyc = 0, n_upd = 0, n_late = 0;
  int             last_end = -1, last_fast = -1, last_slow = -1, ends = 0, late_at = 0;
  longint         integ[3] = '{0, 0, 0}, iref_m = 0, d1_m = 0, d2_m = 0;
  longint         ikp = $rtoi(0.326 * 32768.0 + 0.5), iki = $rtoi(0.0105 * 32768.0 + 0.5);
  longint         ukp = $rtoi(5.648 * 32768.0 + 0.5), uki = $rtoi(0.0428 * 32768.0 + 0.5);

  always #2.5 clock_i = ~clock_i;

  pfcls_top #(.PERIOD_CYC(PER), .MID_CMP(MID), .SLOW_CYC(SLW), .CONV_CYC(CNV)) u_dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .run_i(run_i), .vbus_ref_i(vref),
    .adc_valid_i(valid), .adc_data_i(data), .mid_trig_o(mid_t), .end_trig_o(end_t),
    .adc_start_o(start), .fast_tick_o(fast), .slow_tick_o(slow), .conv_late_o(late),
    .duty_upd_o(upd), .duty1_o(duty1), .duty2_o(duty2), .iref_o(iref), .samples_o(samples));

  pfcls_conv_model u_conv (.clock_i(clock_i), .start_i(start), .mid_i(mid_t), .drop_i(drop),
    .lag_i(lag), .samp_i(samp), .valid_o(valid), .data_o(data));

  // -----------------------------------------------------------------
  // reference model helpers
  // -----------------------------------------------------------------
  function automatic longint sat(longint v, longint lim);
    return (v > lim) ? lim : ((v < -lim - 1) ? -lim - 1 : v);
  endfunction

  function automatic longint pi(int ch, longint r, longint m, longint kp, longint ki);
    longint e;
    e = r - m;
    integ[ch] = sat(integ[ch] + ((e * ki) >>> 15), 2147483647);
    return sat(((e * kp) >>> 15) + integ[ch], 32767);
  endfunction

  function automatic pfcls_frac_t rnd();
    int v;
    v = int'($urandom_range(40000)) - 20000;
    return pfcls_frac_t'(v);
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // bounded wait for a counter of the monitor to advance
  task automatic wait_for(ref int cnt, input int n);
    int target, k;
    target = cnt + n;
    k = 0;
    while (cnt < target && k < 4 * PER * n) begin
      @(posedge clock_i);
      k++;
    end
    if (cnt < target) begin
      fail_count++;
      $display("Error at %0t ns: expected event missing", $time);
      complete_run();
    end else begin
      #1;
    end
  endtask

  // -----------------------------------------------------------------
  // monitor and reference model, sampled mid-cycle
  // -----------------------------------------------------------------
  always @(negedge clock_i) begin
    if (rstn_i) begin
      cyc++;
      if (mid_t | end_t | start) `CHK(start, mid_t | end_t)
      if (mid_t === 1'b1 && last_end >= 0) `CHK(cyc - last_end, MID + 1)
      if (end_t === 1'b1) begin
        if (last_end >= 0) `CHK(cyc - last_end, PER)
        last_end = cyc;
        ends++;
      end
      if (fast === 1'b1) begin
        `CHK(end_t, 1'b1)
        if (last_fast >= 0) `CHK(ends, 2)
        last_fast = cyc;
        ends = 0;
      end
      if (slow === 1'b1) begin
        `CHK(end_t, 1'b1)
        if (last_slow >= 0) `CHK(cyc - last_slow, SLW)
        last_slow = cyc;
        if (run_i) iref_m = sat((pi(2, vref, samp.vbus, ukp, uki) *
          ((samp.vin < 0) ? -longint'(samp.vin) : longint'(samp.vin))) >>> 15, 32767);
      end
      if (late === 1'b1) begin
        n_late++;
        late_at = cyc - last_fast;
      end
      if (upd === 1'b1) begin
        n_upd++;
        d1_m = pi(0, iref_m, samp.i1, ikp, iki);
        d2_m = pi(1, iref_m, samp.i2, ikp, iki);
        if (d1_m < 0) d1_m = 0;
        if (d2_m < 0) d2_m = 0;
        `CHK(cyc - last_fast <= CNV + 5, 1'b1)
        `CHK(samples, samp)
        `CHK(iref, 16'(iref_m))
        `CHK(duty1, 16'(d1_m))
        `CHK(duty2, 16'(d2_m))
        samp = '{rnd(), rnd(), rnd(), rnd(), rnd()};
        lag  = 8'(4 + $urandom_range(56));
      end
      if (!run_i) begin
        integ  = '{0, 0, 0};
        iref_m = 0;
        d1_m   = 0;
        d2_m   = 0;
      end
    end
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    int upd_before;
    void'($urandom(32'hae56));
    samp = '{rnd(), rnd(), rnd(), rnd(), rnd()};
    vref = rnd();
    repeat (5) @(posedge clock_i);
    #1;
    rstn_i = 1'b1;
    run_i  = 1'b1;
    wait_for(n_upd, 12);
    // lost end burst: task skipped, duties hold
    drop = 1'b1;
    upd_before = n_upd;
    wait_for(n_late, 1);
    drop = 1'b0;
    `CHK(late_at >= CNV && late_at <= CNV + 5, 1'b1)
    `CHK(n_upd, upd_before)
    `CHK(duty1, 16'(d1_m))
    // run low clears the loop outputs
    wait_for(n_upd, 1);
    run_i = 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
    `CHK({duty1, duty2, iref}, 48'h0)
    run_i = 1'b1;
    vref  = rnd();
    wait_for(n_upd, 12);
    complete_run();
  end
endmodule
